// >>> inc/tsc_pkg.sv
// package: configuration register map, field positions and hysteresis constants
package tsc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_OFFSET    = 8'h01;     // configuration register pointer
    localparam logic [15:0] CFG_RESET     = 16'h0000;  // configuration reset value
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HYS_HI     = 10;  // hysteresis select msb
    localparam int HYS_LO     = 9;   // hysteresis select lsb
    localparam int SHUT_BIT   = 8;   // shutdown control
    localparam int CRIT_LOCK  = 7;   // critical lock
    localparam int WIN_LOCK   = 6;   // window lock
    localparam int ALERT_CLR  = 5;   // alert clear, write only
    localparam int ALERT_ST   = 4;   // alert state, read only
    localparam int LOW_RW_HI  = 3;   // top of plain read/write alert bits
    localparam int FLAG_CRIT  = 15;  // critical flag in temperature reading
    localparam int FLAG_ABOVE = 14;  // above-window flag
    localparam int FLAG_BELOW = 13;  // below-window flag
    // ------------------------------------------------------------
    // hysteresis in reading units (0.0625 degC per lsb, 13-bit signed)
    // ------------------------------------------------------------
    localparam logic [12:0] HYS_NONE = 13'h0000;  // off
    localparam logic [12:0] HYS_1P5  = 13'h0018;  // 1.5 degC
    localparam logic [12:0] HYS_3P0  = 13'h0030;  // 3 degC
    localparam logic [12:0] HYS_6P0  = 13'h0060;  // 6 degC
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CONV_TIME_MS = 100;                     // conversion period in ms
    localparam int CLK_HZ       = 25000000;                // reference clock
    localparam int CONV_CYCLES  = CLK_HZ / 1000 * CONV_TIME_MS; // cycles per conversion
    // ------------------------------------------------------------
    // post-shutdown phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PH_NORMAL, PH_FIRST, PH_SECOND} tsc_phase_e;
endpackage

// >>> src/tsc_hys_cmp.sv
// module: hysteresis-aware window and critical comparison for one conversion
`timescale 1ns/1ps
module tsc_hys_cmp
    import tsc_pkg::*;
(
    input  wire logic [12:0] temp,       // new signed reading
    input  wire logic [12:0] upper,      // upper boundary
    input  wire logic [12:0] lower,      // lower boundary
    input  wire logic [12:0] crit,       // critical boundary
    input  wire logic [1:0]  hys_sel,    // hysteresis select
    input  wire logic [2:0]  flags,      // previous {crit, above, below}
    input  wire logic        first_conv, // first conversion after shutdown exit
    output logic      [2:0]  flags_nxt   // new {crit, above, below}
);
    logic [12:0] hys;                    // decoded hysteresis
    logic [12:0] up_h;                   // upper minus hysteresis
    logic [12:0] lo_h;                   // lower minus hysteresis
    logic [12:0] cr_h;                   // critical minus hysteresis

    // hysteresis decode
    always_comb
    begin
        case (hys_sel)
            2'b01:   hys = HYS_1P5;
            2'b10:   hys = HYS_3P0;
            2'b11:   hys = HYS_6P0;
            default: hys = HYS_NONE;
        endcase
    end

    // adjusted thresholds in reading units
    always_comb
    begin
        up_h = 13'(upper - hys);
        lo_h = 13'(lower - hys);
        cr_h = 13'(crit - hys);
    end

    // flag decisions; first conversion after exit uses rising view only
    always_comb
    begin
        flags_nxt = flags;
        if (first_conv)
        begin
            flags_nxt[2] = $signed(temp) >= $signed(crit);
            flags_nxt[1] = $signed(temp) > $signed(upper);
            flags_nxt[0] = $signed(temp) <= $signed(lo_h);
        end
        else
        begin
            // above: set above upper, hold until at or below upper minus hysteresis
            if ($signed(temp) > $signed(upper))
                flags_nxt[1] = 1'b1;
            else if ($signed(temp) <= $signed(up_h))
                flags_nxt[1] = 1'b0;
            // below: clear at or above lower, set at or below lower minus hysteresis
            if ($signed(temp) >= $signed(lower))
                flags_nxt[0] = 1'b0;
            else if ($signed(temp) <= $signed(lo_h))
                flags_nxt[0] = 1'b1;
            // critical: same hysteresis scheme
            if ($signed(temp) >= $signed(crit))
                flags_nxt[2] = 1'b1;
            else if ($signed(temp) <= $signed(cr_h))
                flags_nxt[2] = 1'b0;
        end
    end
endmodule

// >>> src/tsc_config.sv
// module: sensor configuration register with hysteresis, shutdown and locks
`timescale 1ns/1ps
module tsc_config
    import tsc_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES       // cycles between conversions
)
(
    input  wire logic        REF_CLK,          // device clock
    input  wire logic        RST,              // power-on reset, async high
    input  wire logic        WR_EN,            // register write strobe
    input  wire logic        RD_EN,            // register read strobe
    input  wire logic [7:0]  PTR,              // register pointer
    input  wire logic [15:0] WR_DATA,          // write data
    input  wire logic [12:0] ADC_TEMP,         // converter result
    input  wire logic        ADC_DONE,         // conversion result valid pulse
    input  wire logic [12:0] UPPER_LIMIT,      // upper boundary
    input  wire logic [12:0] LOWER_LIMIT,      // lower boundary
    input  wire logic [12:0] CRIT_LIMIT,       // critical boundary
    output logic      [15:0] RD_DATA,          // read data
    output logic             RD_VALID,         // read data valid pulse
    output logic      [15:0] TEMP_READING,     // flags plus reading
    output logic             ADC_ENABLE,       // diode and converter enable
    output logic             CONV_TICK,        // conversion start pulse
    output logic             ALERT_ASSERT,     // alert active, before polarity
    output logic             CRIT_LOCKED,      // critical lock state
    output logic             WIN_LOCKED        // window lock state
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0]  hys_r, hys_nxt;               // hysteresis select
    logic        shut_r, shut_nxt;             // shutdown control
    logic        en_r, en_nxt;                 // converter enable, registered for the pin
    logic        clk_r, clk_nxt;               // critical lock
    logic        wlk_r, wlk_nxt;               // window lock
    logic [3:0]  aoc_r, aoc_nxt;               // alert output control, critical only, pol, mode
    logic [2:0]  flg_r, flg_nxt;               // {crit, above, below}
    logic [12:0] tmp_r, tmp_nxt;               // latest reading
    logic        alr_r, alr_nxt;               // alert state
    tsc_phase_e  ph_r, ph_nxt;                 // post-shutdown phase
    logic [31:0] cnt_r, cnt_nxt;               // conversion timer
    logic        tick_r, tick_nxt;             // conversion start pulse
    logic [15:0] rd_r, rd_nxt;                 // read data
    logic        rv_r, rv_nxt;                 // read valid
    logic [2:0]  cmp_flags;                    // comparator result
    logic        locked;                       // any lock set
    logic        cfg_wr;                       // write to configuration

    // ------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------
    tsc_hys_cmp u_cmp (
        .temp       (ADC_TEMP),
        .upper      (UPPER_LIMIT),
        .lower      (LOWER_LIMIT),
        .crit       (CRIT_LIMIT),
        .hys_sel    (hys_r),
        .flags      (flg_r),
        .first_conv (ph_r == PH_FIRST),
        .flags_nxt  (cmp_flags)
    );

    // configuration image for read-back
    function automatic logic [15:0] cfg_image(input logic [1:0] h, input logic s,
                                              input logic cl, input logic wl,
                                              input logic a, input logic [3:0] o);
        cfg_image = {5'h00, h, s, cl, wl, 1'b0, a, o};
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        locked   = clk_r | wlk_r;
        cfg_wr   = WR_EN && (PTR == CFG_OFFSET);
        hys_nxt  = hys_r;
        shut_nxt = shut_r;
        clk_nxt  = clk_r;
        wlk_nxt  = wlk_r;
        aoc_nxt  = aoc_r;
        flg_nxt  = flg_r;
        tmp_nxt  = tmp_r;
        alr_nxt  = alr_r;
        ph_nxt   = ph_r;
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        rv_nxt   = RD_EN;
        rd_nxt   = rd_r;
        // register read; other pointers read zero here
        if (RD_EN)
        begin
            if (PTR == CFG_OFFSET)
                rd_nxt = cfg_image(hys_r, shut_r, clk_r, wlk_r, alr_r, aoc_r);
            else
                rd_nxt = 16'h0000;
        end
        // conversion timer, idle in shutdown
        if (shut_r)
            cnt_nxt = 32'h0000_0000;
        else if (cnt_r >= 32'(CONV_CNT - 1))
        begin
            cnt_nxt  = 32'h0000_0000;
            tick_nxt = 1'b1;
        end
        else
            cnt_nxt = cnt_r + 32'h0000_0001;
        // conversion result
        if (ADC_DONE && !shut_r)
        begin
            tmp_nxt = ADC_TEMP;
            flg_nxt = cmp_flags;
            // alert follows flags, hysteresis included via comparator
            alr_nxt = aoc_r[2] ? cmp_flags[2] : |cmp_flags;
            case (ph_r)
                PH_FIRST:  ph_nxt = PH_SECOND;
                PH_SECOND: ph_nxt = PH_NORMAL;
                default:   ph_nxt = PH_NORMAL;
            endcase
        end
        // configuration write
        if (cfg_wr)
        begin
            if (!locked)
                hys_nxt = WR_DATA[HYS_HI:HYS_LO];
            if (!WR_DATA[SHUT_BIT])
                shut_nxt = 1'b0;
            else if (!locked)
                shut_nxt = 1'b1;
            if (WR_DATA[CRIT_LOCK])
                clk_nxt = 1'b1;
            if (WR_DATA[WIN_LOCK])
                wlk_nxt = 1'b1;
            aoc_nxt = WR_DATA[LOW_RW_HI:0];
            if (WR_DATA[ALERT_CLR] && !(ADC_DONE && !shut_r))
                alr_nxt = 1'b0;
            // leaving shutdown: clear flags, clear alert, restart conversions
            if (shut_r && !WR_DATA[SHUT_BIT])
            begin
                flg_nxt = 3'b000;
                alr_nxt = 1'b0;
                ph_nxt  = PH_FIRST;
            end
        end
        // no events while shut down
        if (shut_nxt)
            alr_nxt = 1'b0;
        // converter enable follows the settled shutdown decision
        en_nxt = !shut_nxt;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            hys_r  <= CFG_RESET[HYS_HI:HYS_LO];
            shut_r <= CFG_RESET[SHUT_BIT];
            en_r   <= !CFG_RESET[SHUT_BIT];
            clk_r  <= CFG_RESET[CRIT_LOCK];
            wlk_r  <= CFG_RESET[WIN_LOCK];
            aoc_r  <= CFG_RESET[LOW_RW_HI:0];
            flg_r  <= 3'h0;
            tmp_r  <= 13'h0000;
            alr_r  <= 1'b0;
            ph_r   <= PH_NORMAL;
            cnt_r  <= 32'h0000_0000;
            tick_r <= 1'b0;
            rd_r   <= 16'h0000;
            rv_r   <= 1'b0;
        end
        else
        begin
            hys_r  <= hys_nxt;
            shut_r <= shut_nxt;
            en_r   <= en_nxt;
            clk_r  <= clk_nxt;
            wlk_r  <= wlk_nxt;
            aoc_r  <= aoc_nxt;
            flg_r  <= flg_nxt;
            tmp_r  <= tmp_nxt;
            alr_r  <= alr_nxt;
            ph_r   <= ph_nxt;
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
            rd_r   <= rd_nxt;
            rv_r   <= rv_nxt;
        end
    end

    // outputs straight from flops
    assign RD_DATA      = rd_r;
    assign RD_VALID     = rv_r;
    assign TEMP_READING = {flg_r, tmp_r};
    assign ADC_ENABLE   = en_r;
    assign CONV_TICK    = tick_r;
    assign ALERT_ASSERT = alr_r;
    assign CRIT_LOCKED  = clk_r;
    assign WIN_LOCKED   = wlk_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_hys_locked: assert property (@(posedge REF_CLK) disable iff (RST)
        (clk_r | wlk_r) |=> $stable(hys_r))
        else $error("hysteresis changed while locked");
    a_shut_refused: assert property (@(posedge REF_CLK) disable iff (RST)
        ((clk_r | wlk_r) && !shut_r) |=> !shut_r)
        else $error("shutdown set while locked");
    a_shut_clear: assert property (@(posedge REF_CLK) disable iff (RST)
        (WR_EN && PTR == CFG_OFFSET && !WR_DATA[SHUT_BIT]) |=> !shut_r)
        else $error("shutdown clear refused");
    a_lock_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
        clk_r |=> clk_r)
        else $error("critical lock dropped");
    a_shut_frozen: assert property (@(posedge REF_CLK) disable iff (RST)
        (shut_r && shut_nxt) |=> ($stable(tmp_r) && !alr_r && !ADC_ENABLE))
        else $error("activity during shutdown");
    a_exit_clear: assert property (@(posedge REF_CLK) disable iff (RST)
        (shut_r && !shut_nxt) |=> (flg_r == 3'b000 && ph_r == PH_FIRST))
        else $error("flags not cleared on exit");
    a_exit_alert: assert property (@(posedge REF_CLK) disable iff (RST)
        (ph_r == PH_FIRST) |-> !alr_r)
        else $error("alert during first conversion");
    a_rsvd_zero: assert property (@(posedge REF_CLK) disable iff (RST)
        RD_VALID |-> (RD_DATA[15:11] == 5'h00))
        else $error("reserved bits nonzero");
    a_read_shut: assert property (@(posedge REF_CLK) disable iff (RST)
        RD_EN |=> RD_VALID)
        else $error("read not answered");
endmodule

// >>> tb/tsc_adc_model.sv
// converter model: answers each conversion start with one reading
`timescale 1ns/1ps
module tsc_adc_model
(
    input  wire logic        clk,      // device clock
    input  wire logic        rst,      // power-on reset
    input  wire logic        start,    // conversion start pulse
    input  wire logic [12:0] temp_in,  // temperature to report
    output logic      [12:0] adc_temp, // result, scrambled while not valid
    output logic             adc_done  // result valid pulse
);
    // ----------------------------------------
    // one reading a cycle after each start
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_done <= 1'b0;
            adc_temp <= 13'h1555;
        end
        else
        begin
            adc_done <= start;                      // no start, no result
            adc_temp <= start ? temp_in : ~adc_temp; // stale value never holds
        end
    end
endmodule

// >>> tb/tsc_config_bench.sv
// testbench: configuration register, hysteresis, shutdown and locks
`timescale 1ns/1ps
module tsc_config_bench;
    import tsc_pkg::*;
    localparam int          CC = 16;        // shortened conversion period
    localparam logic [12:0] UP = 13'h0200;  // upper boundary
    localparam logic [12:0] LO = 13'h1F00;  // lower boundary, negative
    logic        clk = 1'b0;                // device clock
    logic        rst, wr_en, rd_en, adc_done, rd_valid, adc_en, tick, alert, cl, wl;
    logic [7:0]  ptr;                       // register pointer
    logic [15:0] wr_data, rd_data, reading; // bus data and temperature word
    logic [12:0] temp, adc_temp;            // model input and converter result
    logic [12:0] hys [4] = '{HYS_NONE, HYS_1P5, HYS_3P0, HYS_6P0}; // steps
    int          fail_count = 0;            // mismatches
    int          total_checks = 0;          // comparisons
    int          i, n;                      // loop counters
    always #20 clk = ~clk;
    // ----------------------------------------
    // design and converter model
    // ----------------------------------------
    tsc_config #(.CONV_CNT(CC)) u_tsc_config (.REF_CLK(clk), .RST(rst), .WR_EN(wr_en),
        .RD_EN(rd_en), .PTR(ptr), .WR_DATA(wr_data), .ADC_TEMP(adc_temp),
        .ADC_DONE(adc_done), .UPPER_LIMIT(UP), .LOWER_LIMIT(LO), .CRIT_LIMIT(13'h0800),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .TEMP_READING(reading),
        .ADC_ENABLE(adc_en), .CONV_TICK(tick), .ALERT_ASSERT(alert),
        .CRIT_LOCKED(cl), .WIN_LOCKED(wl));
    tsc_adc_model u_tsc_adc_model (.clk(clk), .rst(rst), .start(tick), .temp_in(temp),
        .adc_temp(adc_temp), .adc_done(adc_done));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_data = d;
        ptr = CFG_OFFSET;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] exp);
        @(negedge clk);
        rd_en = 1'b1;
        ptr = CFG_OFFSET;
        @(negedge clk);
        rd_en = 1'b0;
        check({15'h0, rd_valid}, 16'h0001);
        check(rd_data, exp);
    endtask
    // wait for one converter result, alert optionally required low meanwhile
    task automatic wait_done(input logic hold_off);
        for (n = 0; n < 4 * CC && adc_done !== 1'b1; n++)
        begin
            if (hold_off)
                check({15'h0, alert}, 16'h0000);
            @(negedge clk);
        end
        if (n >= 4 * CC)
        begin
            fail_count++;
            tally_and_finish();
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic expect_flags(input logic [2:0] f);
        check(reading, {f, temp});
        check({15'h0, alert}, {15'h0, |f});
    endtask
    task automatic conv(input logic [12:0] t, input logic [2:0] f);
        temp = t;
        wait_done(1'b0);
        wait_done(1'b0);
        expect_flags(f);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ptr = 8'h00;
        wr_data = 16'h0000;
        temp = 13'h0000;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(CFG_RESET);
        check({14'h0, cl, wl}, 16'h0000);
        wr(16'h000F);
        rd(16'h000F);
        $display("test reset and reserved bits done");
        for (i = 0; i < 4; i++)
        begin
            wr({5'h00, i[1:0], 9'h000});
            conv(UP + 13'h1, 3'b010);
            conv(UP - hys[i] + 13'h1, 3'b010);
            conv(UP - hys[i], 3'b000);
            conv(LO - hys[i] + 13'h1, 3'b000);
            conv(LO - hys[i], (i == 0) ? 3'b000 : 3'b001);
            conv(LO - 13'h1, 3'b001);
            conv(LO, 3'b000);
        end
        $display("test hysteresis steps done");
        wr(16'h0400);
        conv(UP + 13'h1, 3'b010);
        wr(16'h0500);
        check({15'h0, adc_en}, 16'h0000);
        temp = LO - 13'h0100;
        // let a conversion launched just before entry drain out
        @(negedge clk);
        for (n = 0; n < 3 * CC; n++)
        begin
            @(negedge clk);
            check({14'h0, tick, adc_done}, 16'h0000);
        end
        check(reading, {3'b010, UP + 13'h1});
        rd(16'h0500);
        temp = UP - 13'h0010;
        wr(16'h0400);
        check({reading[15:13], alert}, 16'h0000);
        check({15'h0, adc_en}, 16'h0001);
        wait_done(1'b1);
        expect_flags(3'b000);
        conv(LO - HYS_3P0, 3'b001);
        rd(16'h0410);
        conv(13'h0000, 3'b000);
        $display("test shutdown and exit done");
        wr(16'h0480);
        check({14'h0, cl, wl}, 16'h0002);
        rd(16'h0480);
        wr(16'h0680);
        rd(16'h0480);
        wr(16'h0580);
        rd(16'h0480);
        check({15'h0, adc_en}, 16'h0001);
        wr(16'h0000);
        rd(16'h0480);
        wr(16'h04C0);
        check({14'h0, cl, wl}, 16'h0003);
        rd(16'h04C0);
        $display("test locks done");
        tally_and_finish();
    end
endmodule
